/* File: logic/fmev_pkg.sv */
package fmev_pkg;
    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_PARAM = 8'h00;   // Parameter word at current index
    localparam logic [7:0] ADDR_INDEX = 8'h04;   // Command word index
    localparam logic [7:0] ADDR_STATUS = 8'h08;  // Flash status register
    localparam logic [7:0] ADDR_MODE = 8'h0c;    // Operating mode control
    localparam logic [7:0] ADDR_MARGIN = 8'h10;  // Applied margin levels (read only)
    localparam logic [7:0] ADDR_RDERR = 8'h14;   // Not decoded by the sequencer; reads return zero

    // ****************************************************************
    // Status and mode field positions
    // ****************************************************************
    localparam int ST_VERIFY_UNCORR = 0;
    localparam int ST_VERIFY_ERR = 1;
    localparam int ST_PROT_VIOL = 4;
    localparam int ST_ACCESS_ERR = 5;
    localparam int ST_COMPLETE = 7;
    localparam int MODE_SPECIAL = 0;

    // ****************************************************************
    // Command codes, block selectors, margin encodings
    // ****************************************************************
    localparam logic [7:0] CMD_USER_MARGIN = 8'h0d;
    localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0e;
    localparam logic [7:0] CMD_ERASE_VERIFY = 8'h10;
    localparam logic [1:0] BLK_DFLASH = 2'h0;
    localparam logic [1:0] BLK_PFLASH = 2'h1;
    localparam logic [2:0] IDX_MARGIN = 3'h1;
    localparam logic [2:0] IDX_VERIFY = 3'h2;
    localparam logic [15:0] LVL_NORMAL = 16'h0000;
    localparam logic [15:0] LVL_USER_M1 = 16'h0001;
    localparam logic [15:0] LVL_USER_M0 = 16'h0002;
    localparam logic [15:0] LVL_FIELD_M1 = 16'h0003;
    localparam logic [15:0] LVL_FIELD_M0 = 16'h0004;

    // ****************************************************************
    // Data flash geometry and reset values
    // ****************************************************************
    localparam logic [15:0] DF_BASE = 16'h4400;
    localparam logic [16:0] DF_END = 17'h0_5400;   // One past last byte
    localparam logic [31:0] STATUS_RESET = 32'h0000_0080;
    localparam int VERIFY_WORD_CYCLES = 1;

    typedef enum logic [1:0] {FMEV_IDLE, FMEV_CHECK, FMEV_VERIFY, FMEV_DONE} fmev_state_t;
endpackage

/* File: logic/fmev_sequencer.sv */
// Added by the designer: register access over APB and the address map.
`timescale 1ns/10ps
// Notes on behaviour
// - Margin commands raise access error unless word index is 001 at launch.
// - Command not permitted in current mode raises access error.
// - Margin commands raise access error for an invalid block selector.
// - Margin commands raise access error for an invalid level setting.
// - Field margin command 0x0E only allowed in special mode.
// - Word 000 holds code and block selector; word 001 holds level.
// - Valid field margin launch applies the level, then sets complete.
// - Data flash level affects data reads; program level affects both.
// - Levels 0 normal, 1 user-1, 2 user-0, 3 field-1, 4 field-0.
// - Margin-1 shifts toward erased, margin-0 toward programmed.
// - Erase verify 0x10 uses block from 000, address 001, count 010.
// - Valid erase verify checks each section word, then sets complete.
// - Erase verify raises access error unless word index is 010.
// - Erase verify raises access error if address is outside data flash.
// - Erase verify raises access error for an odd start address.
// - Erase verify raises access error if section runs past flash end.
// - Verify sets error flags on read faults; never protection flag.
// - User margin 0x0D applies the level, then sets complete.
// - User margin accepts only levels 0, 1 and 2.
module fmev_sequencer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [15:0] df_read_addr,
    input wire logic df_read_err,
    input wire logic df_read_uncorr,
    output logic [2:0] pf_read_margin,
    output logic [2:0] df_read_margin,
    output logic command_busy
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [15:0] command_parameter_words_ff [0:2];
    logic [2:0] command_word_index_ff;
    logic command_complete_flag_ff;
    logic access_error_flag_ff;
    logic protection_violation_flag_ff;
    logic verify_error_flag_ff;
    logic verify_uncorrectable_flag_ff;
    logic special_mode_ff;
    logic [2:0] pf_margin_ff;
    logic [2:0] df_margin_ff;
    logic [15:0] addr_ff;
    logic [15:0] count_ff;
    logic [31:0] prdata_ff;
    fmev_pkg::fmev_state_t state_ff;
    fmev_pkg::fmev_state_t nxt_state;

    logic wr_en;
    logic rd_en;
    logic launch;
    logic chk_err;
    logic [7:0] cmd_code;
    logic [1:0] blk_sel;
    logic [15:0] level;
    logic [17:0] sec_end;

    // Decode a level setting into the 3-bit read threshold code
    function automatic logic [2:0] fmev_level_code(input logic [15:0] lvl);
        fmev_level_code = lvl[2:0];
    endfunction

    // Valid block selector check
    function automatic logic fmev_blk_ok(input logic [1:0] b);
        fmev_blk_ok = (b == fmev_pkg::BLK_DFLASH) || (b == fmev_pkg::BLK_PFLASH);
    endfunction

    // ****************************************************************
    // APB access
    // ****************************************************************
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = prdata_ff;
    assign command_busy = !command_complete_flag_ff;
    assign pf_read_margin = pf_margin_ff;
    assign df_read_margin = df_margin_ff;
    assign df_read_addr = addr_ff;

    // Launch when software writes one to the complete flag bit while idle
    assign launch = wr_en && (paddr == fmev_pkg::ADDR_STATUS) && pwdata[fmev_pkg::ST_COMPLETE]
                    && command_complete_flag_ff;

    // Parameter word fields
    assign cmd_code = command_parameter_words_ff[0][15:8];
    assign blk_sel = command_parameter_words_ff[0][1:0];
    assign level = command_parameter_words_ff[1];
    // One spare bit so a huge word count cannot wrap past the end check
    assign sec_end = {2'b00, command_parameter_words_ff[1]} + {1'b0, command_parameter_words_ff[2], 1'b0};

    // Launch checks
    always_comb begin
        chk_err = 1'b0;
        case (cmd_code)
            fmev_pkg::CMD_USER_MARGIN, fmev_pkg::CMD_FIELD_MARGIN: begin
                if (command_word_index_ff != fmev_pkg::IDX_MARGIN) chk_err = 1'b1;
                if (!fmev_blk_ok(blk_sel)) chk_err = 1'b1;
                if (cmd_code == fmev_pkg::CMD_USER_MARGIN && level > fmev_pkg::LVL_USER_M0) begin
                    chk_err = 1'b1;
                end
                if (cmd_code == fmev_pkg::CMD_FIELD_MARGIN && level > fmev_pkg::LVL_FIELD_M0) begin
                    chk_err = 1'b1;
                end
                if (cmd_code == fmev_pkg::CMD_FIELD_MARGIN && !special_mode_ff) chk_err = 1'b1;
            end
            fmev_pkg::CMD_ERASE_VERIFY: begin
                if (command_word_index_ff != fmev_pkg::IDX_VERIFY) chk_err = 1'b1;
                if (blk_sel != fmev_pkg::BLK_DFLASH || level < fmev_pkg::DF_BASE
                    || {1'b0, level} >= fmev_pkg::DF_END) chk_err = 1'b1;
                if (level[0]) chk_err = 1'b1;
                if (sec_end > {1'b0, fmev_pkg::DF_END}) chk_err = 1'b1;
            end
            default: begin
                chk_err = 1'b1;
            end
        endcase
    end

    // Sequencer next state
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            fmev_pkg::FMEV_IDLE: begin
                if (launch) nxt_state = fmev_pkg::FMEV_CHECK;
            end
            fmev_pkg::FMEV_CHECK: begin
                if (chk_err) nxt_state = fmev_pkg::FMEV_DONE;
                else if (cmd_code == fmev_pkg::CMD_ERASE_VERIFY && count_ff != 16'h0000) begin
                    nxt_state = fmev_pkg::FMEV_VERIFY;
                end else nxt_state = fmev_pkg::FMEV_DONE;
            end
            fmev_pkg::FMEV_VERIFY: begin
                if (count_ff == 16'h0001) nxt_state = fmev_pkg::FMEV_DONE;
            end
            fmev_pkg::FMEV_DONE: begin
                nxt_state = fmev_pkg::FMEV_IDLE;
            end
            default: begin
                nxt_state = fmev_pkg::FMEV_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) state_ff <= fmev_pkg::FMEV_IDLE;
        else state_ff <= nxt_state;
    end

    // Parameter words written at the current index, index register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_parameter_words_ff[0] <= 16'h0000;
            command_parameter_words_ff[1] <= 16'h0000;
            command_parameter_words_ff[2] <= 16'h0000;
            command_word_index_ff <= 3'h0;
        end else if (command_complete_flag_ff && wr_en) begin
            if (paddr == fmev_pkg::ADDR_INDEX) command_word_index_ff <= pwdata[2:0];
            if (paddr == fmev_pkg::ADDR_PARAM && command_word_index_ff <= 3'h2) begin
                command_parameter_words_ff[command_word_index_ff[1:0]] <= pwdata[15:0];
            end
        end
    end

    // Mode control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) special_mode_ff <= 1'b0;
        else if (wr_en && paddr == fmev_pkg::ADDR_MODE) special_mode_ff <= pwdata[fmev_pkg::MODE_SPECIAL];
    end

    // Complete flag: cleared by launch, set when sequence ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) command_complete_flag_ff <= 1'b1;
        else if (state_ff == fmev_pkg::FMEV_DONE) command_complete_flag_ff <= 1'b1;
        else if (launch) command_complete_flag_ff <= 1'b0;
    end

    // Access error: set on failed check, cleared by writing one; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) access_error_flag_ff <= 1'b0;
        else if (state_ff == fmev_pkg::FMEV_CHECK && chk_err) access_error_flag_ff <= 1'b1;
        else if (launch) access_error_flag_ff <= 1'b0;
        else if (wr_en && paddr == fmev_pkg::ADDR_STATUS && pwdata[fmev_pkg::ST_ACCESS_ERR]) begin
            access_error_flag_ff <= 1'b0;
        end
    end

    // Protection violation never raised by these commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) protection_violation_flag_ff <= 1'b0;
        else if (launch) protection_violation_flag_ff <= 1'b0;
    end

    // Verify status flags, cleared at launch, set on read faults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            verify_error_flag_ff <= 1'b0;
            verify_uncorrectable_flag_ff <= 1'b0;
        end else if (launch) begin
            verify_error_flag_ff <= 1'b0;
            verify_uncorrectable_flag_ff <= 1'b0;
        end else if (state_ff == fmev_pkg::FMEV_VERIFY) begin
            if (df_read_err || df_read_uncorr) verify_error_flag_ff <= 1'b1;
            if (df_read_uncorr) verify_uncorrectable_flag_ff <= 1'b1;
        end
    end

    // Section walk: address and remaining word count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_ff <= 16'h0000;
            count_ff <= 16'h0000;
        end else if (state_ff == fmev_pkg::FMEV_IDLE && launch) begin
            addr_ff <= command_parameter_words_ff[1];
            count_ff <= command_parameter_words_ff[2];
        end else if (state_ff == fmev_pkg::FMEV_VERIFY) begin
            addr_ff <= addr_ff + 16'h0002;
            count_ff <= count_ff - 16'h0001;
        end
    end

    // Margin levels applied to read paths
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pf_margin_ff <= 3'h0;
            df_margin_ff <= 3'h0;
        end else if (state_ff == fmev_pkg::FMEV_CHECK && !chk_err && cmd_code != fmev_pkg::CMD_ERASE_VERIFY) begin
            if (blk_sel == fmev_pkg::BLK_PFLASH) begin
                pf_margin_ff <= fmev_level_code(level);
                df_margin_ff <= fmev_level_code(level);
            end else begin
                df_margin_ff <= fmev_level_code(level);
            end
        end
    end

    // Read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata_ff <= 32'h0000_0000;
        else if (rd_en) begin
            case (paddr)
                fmev_pkg::ADDR_PARAM: prdata_ff <= {16'h0000,
                    command_parameter_words_ff[(command_word_index_ff <= 3'h2) ? command_word_index_ff[1:0] : 2'h0]};
                fmev_pkg::ADDR_INDEX: prdata_ff <= {29'h0, command_word_index_ff};
                fmev_pkg::ADDR_STATUS: prdata_ff <= {24'h0, command_complete_flag_ff, 1'b0, access_error_flag_ff,
                    protection_violation_flag_ff, 2'b00, verify_error_flag_ff, verify_uncorrectable_flag_ff};
                fmev_pkg::ADDR_MODE: prdata_ff <= {31'h0, special_mode_ff};
                fmev_pkg::ADDR_MARGIN: prdata_ff <= {24'h0, 1'b0, df_margin_ff, 1'b0, pf_margin_ff};
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

endmodule

/* File: tb/fmev_sequencer_assertions.sv */
`timescale 1ns/10ps
module fmev_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [15:0] df_read_addr,
    input wire logic [2:0] pf_read_margin,
    input wire logic [2:0] df_read_margin,
    input wire logic command_busy
);
    // ****************************************************************
    // Launch and status read decode
    // ****************************************************************
    logic launch;
    logic stat_rd;
    assign launch = psel && penable && pwrite && !command_busy && paddr == fmev_pkg::ADDR_STATUS && pwdata[7];
    assign stat_rd = psel && penable && !pwrite && paddr == fmev_pkg::ADDR_STATUS;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_launch_busy; launch |=> command_busy [*2]; endproperty
    a_launch_busy: assert property (p_launch_busy) else $error("busy not held after launch");
    property p_busy_cause; $rose(command_busy) |-> $past(launch); endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy rose without launch");
    property p_margin_busy; (!$stable(pf_read_margin) || !$stable(df_read_margin)) |-> command_busy; endproperty
    a_margin_busy: assert property (p_margin_busy) else $error("margin moved outside command");
    property p_pf_range; pf_read_margin <= 3'h4; endproperty
    a_pf_range: assert property (p_pf_range) else $error("program margin code out of range");
    property p_df_range; df_read_margin <= 3'h4; endproperty
    a_df_range: assert property (p_df_range) else $error("data margin code out of range");
    property p_no_prot; stat_rd |-> !prdata[fmev_pkg::ST_PROT_VIOL]; endproperty
    a_no_prot: assert property (p_no_prot) else $error("protection flag seen set");
    property p_addr_step; (!$stable(df_read_addr) && command_busy && $past(command_busy))
        |-> df_read_addr == $past(df_read_addr) + 16'h0002; endproperty
    a_addr_step: assert property (p_addr_step) else $error("verify address did not step by two");
    property p_addr_end; (!$stable(df_read_addr) && command_busy && $past(command_busy))
        |-> df_read_addr <= 16'h5400; endproperty
    a_addr_end: assert property (p_addr_end) else $error("verify ran past data flash end");
    property p_bus_ok; (psel && penable) |-> (pready && !pslverr); endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus access not answered cleanly");
endmodule
bind fmev_sequencer fmev_checker fmev_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .df_read_addr(df_read_addr), .pf_read_margin(pf_read_margin), .df_read_margin(df_read_margin),
    .command_busy(command_busy), .pready(pready), .pslverr(pslverr));

/* File: tb/fmev_sequencer_tb.sv */
`timescale 1ns/10ps
module fmev_sequencer_tb;
    localparam logic [7:0] ST = fmev_pkg::ADDR_STATUS;
    localparam logic [7:0] MG = fmev_pkg::ADDR_MARGIN;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic df_read_err = 1'b0, df_read_uncorr = 1'b0, pready, pslverr, command_busy;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [15:0] df_read_addr;
    logic [2:0] pf_read_margin, df_read_margin, pf_m = 3'h0, df_m = 3'h0;
    logic [63:0] expq[$];
    logic [7:0] rnd = 8'h58;
    int bad_count = 0, checks = 0, cyc = 0;
    always #4 pclk = ~pclk;
    fmev_sequencer fmev_sequencer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .df_read_addr(df_read_addr), .df_read_err(df_read_err), .df_read_uncorr(df_read_uncorr),
        .pf_read_margin(pf_read_margin), .df_read_margin(df_read_margin), .command_busy(command_busy));
    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Oldest note against each completed read
    always @(negedge pclk) begin
        if (psel && penable && !pwrite && pready === 1'b1 && expq.size() > 0) begin
            chk(prdata & expq[0][63:32], expq[0][31:0]);
            void'(expq.pop_front());
        end
    end
    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            results();
        end
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // ****************************************************************
    // Bus and command tasks
    // ****************************************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        expq.push_back({m, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [1:0] b, input logic [15:0] w1, input logic [15:0] w2,
        input logic [2:0] ix);
        logic [15:0] wd [3];
        int n;
        wd = '{{c, 6'h00, b}, w1, w2};
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, fmev_pkg::ADDR_INDEX, 32'(i));
            apb(1'b1, fmev_pkg::ADDR_PARAM, {16'h0000, wd[i]});
        end
        apb(1'b1, fmev_pkg::ADDR_INDEX, {29'h0, ix});
        apb(1'b1, ST, 32'h0000_0080);
        n = 0;
        while (command_busy !== 1'b0 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic marg(input logic [7:0] c, input logic [1:0] b, input logic [2:0] lv, input logic [2:0] ix,
        input logic ok);
        cmd(c, b, {13'h0, lv}, 16'h0000, ix);
        if (ok && b == fmev_pkg::BLK_PFLASH) pf_m = lv;
        if (ok) df_m = lv;
        rd(ST, 32'h0000_00b3, ok ? 32'h0000_0080 : 32'h0000_00a0);
        rd(MG, 32'h0000_0077, {25'h0, df_m, 1'b0, pf_m});
    endtask
    task automatic ver(input logic [1:0] b, input logic [15:0] a, input logic [15:0] n, input logic [2:0] ix,
        input logic ok, input logic e, input logic u);
        df_read_err <= e;
        df_read_uncorr <= u;
        cmd(fmev_pkg::CMD_ERASE_VERIFY, b, a, n, ix);
        rd(ST, 32'h0000_00b3, ok ? {24'h0, 1'b1, 5'h00, (e || u) && n != 0, u && n != 0} : 32'h0000_00a0);
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ST, 32'hffff_ffff, fmev_pkg::STATUS_RESET);
        rd(MG, 32'h0000_0077, 32'h0000_0000);
        rd(8'h1c, 32'hffff_ffff, 32'h0000_0000);
        $display("reset and map test done");
        for (int b = 1; b >= 0; b--) begin
            for (int i = 0; i < 3; i++) begin
                marg(fmev_pkg::CMD_USER_MARGIN, b[1:0], 3'(b ? (i + 1) % 3 : i), 3'h1, 1'b1);
            end
        end
        apb(1'b1, fmev_pkg::ADDR_MODE, 32'h0000_0001);
        for (int b = 1; b >= 0; b--) begin
            for (int i = 0; i < 5; i++) begin
                marg(fmev_pkg::CMD_FIELD_MARGIN, b[1:0], 3'(b ? (i + 1) % 5 : i), 3'h1, 1'b1);
            end
        end
        $display("margin level test done");
        marg(fmev_pkg::CMD_USER_MARGIN, 2'h0, 3'h3, 3'h1, 1'b0);
        marg(fmev_pkg::CMD_FIELD_MARGIN, 2'h0, 3'h5, 3'h1, 1'b0);
        marg(fmev_pkg::CMD_USER_MARGIN, 2'h2, 3'h1, 3'h1, 1'b0);
        marg(fmev_pkg::CMD_FIELD_MARGIN, 2'h0, 3'h1, 3'h2, 1'b0);
        marg(fmev_pkg::CMD_USER_MARGIN, 2'h1, 3'h1, 3'h0, 1'b0);
        apb(1'b1, fmev_pkg::ADDR_MODE, 32'h0000_0000);
        marg(fmev_pkg::CMD_FIELD_MARGIN, 2'h0, 3'h1, 3'h1, 1'b0);
        marg(8'h11, 2'h0, 3'h0, 3'h1, 1'b0);
        // Write one to the access error bit clears it without a launch
        apb(1'b1, ST, 32'h0000_0020);
        rd(ST, 32'h0000_00b3, 32'h0000_0080);
        $display("margin error test done");
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            ver(2'h0, 16'h4400 + {7'h0, rnd, 1'b0}, {13'h0, rnd[6:4]}, 3'h2, 1'b1, rnd[0], rnd[0] & rnd[1]);
        end
        ver(2'h0, 16'h53fe, 16'h0001, 3'h2, 1'b1, 1'b0, 1'b0);
        ver(2'h0, 16'h53fe, 16'h0002, 3'h2, 1'b0, 1'b0, 1'b0);
        ver(2'h0, 16'h4400, 16'hffff, 3'h2, 1'b0, 1'b0, 1'b0);
        ver(2'h0, 16'h4401, 16'h0001, 3'h2, 1'b0, 1'b0, 1'b0);
        ver(2'h0, 16'h43fe, 16'h0001, 3'h2, 1'b0, 1'b0, 1'b0);
        ver(2'h1, 16'h4400, 16'h0001, 3'h2, 1'b0, 1'b0, 1'b0);
        ver(2'h0, 16'h4400, 16'h0001, 3'h1, 1'b0, 1'b0, 1'b0);
        $display("erase verify test done");
        results();
    end
endmodule
